//--- hw/exception_vector_status.sv
// interrupt control and state register: pending, active and return-to-base status
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module exception_vector_status (
  input wire logic clk, // system clock, 10 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // register write data
  input wire logic wr, // write strobe, one cycle
  input wire logic rd, // read strobe, one cycle
  output logic [31:0] rdata, // read data, valid the cycle after rd
  input wire logic [63:0] pend_in, // pending flag per exception number
  input wire logic [63:0] enable_in, // enable flag per exception number
  input wire logic [191:0] prio_in, // 3-bit priority per exception number
  input wire logic [63:0] active_in, // active flag per exception number
  input wire logic [5:0] handler_exception_number, // exception number of program status
  output logic [5:0] pending_vector_number, // highest priority eligible pending code
  output logic [5:0] active_vector_number, // code now being serviced
  output logic return_to_base_flag, // no preempted ordinary actives remain
  output logic [7:0] base_priority_mask, // software base priority level
  output logic fault_mask_a // software fault mask
);
  // timing seen from outside:
  //   status outputs show the exception state sampled at the previous clock;
  //   a mask write reaches its outputs and the pick one clock later;
  //   read data stands for exactly one clock after the read strobe and is zero otherwise;
  //   there is no primary mask input, so the pending field can never be hidden by it;
  //   the return flag is computed in thread mode too, software must not read meaning into it there
  typedef struct packed {
    logic [31:0] rdata;
    logic [7:0] base_pri;
    logic fmask;
    logic [5:0] pend;
    logic [5:0] act;
    logic ret_flag;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic [5:0] winner;
  logic [63:0] others;
  logic ret_flag_now;
  logic [5:0] act_now;
  logic [31:0] ics_word;
  logic [31:0] mask_word;

  // address decode, shared by the next-state logic (hit_mask only) and the checks
  function automatic logic hit_status(input logic [7:0] a);
    hit_status = a == exc_status_pkg::ICS_OFFSET;
  endfunction : hit_status

  function automatic logic hit_mask(input logic [7:0] a);
    hit_mask = a == exc_status_pkg::MASK_OFFSET;
  endfunction : hit_mask

  // priority resolution over all exceptions
  exc_prio_pick u_pick (
    .pend_in(pend_in),
    .enable_in(enable_in),
    .prio_in(prio_in),
    .base_pri(cur.base_pri[7:exc_status_pkg::BPRI_IMPL_LSB]),
    .fmask(cur.fmask),
    .winner(winner)
  );

  // ordinary actives other than the running handler; nmi and faults never count
  for (genvar i = 0; i < exc_status_pkg::NUM_EXC; i++)
  begin : g_other
    assign others[i] = active_in[i] && exc_status_pkg::code_is_ordinary(6'(i)) &&
      handler_exception_number != 6'(i);
  end

  // flag is computed in thread mode too; software reads it only inside a handler
  assign ret_flag_now = ~|others;

  // active code mirrors the program status; a reserved code never gets through
  assign act_now = exc_status_pkg::code_is_legal(handler_exception_number) ?
    handler_exception_number : exc_status_pkg::EXC_NONE;

  // readable images: status bits 10:6 and 31:18 and mask bits 31:9 are tied to zero
  always_comb
  begin
    ics_word = 32'h0000_0000;
    ics_word[exc_status_pkg::PEND_LSB +: 6] = cur.pend;
    ics_word[exc_status_pkg::RET_FLAG_BIT] = cur.ret_flag;
    ics_word[exc_status_pkg::ACT_LSB +: 6] = cur.act;
    mask_word = 32'h0000_0000;
    mask_word[exc_status_pkg::BPRI_LSB +: 8] = cur.base_pri;
    mask_word[exc_status_pkg::FMASK_BIT] = cur.fmask;
  end

  // next state: status tracks every clock, registers take writes, reads answer next cycle
  always_comb
  begin
    next_cur = cur;
    next_cur.pend = winner;
    next_cur.act = act_now;
    next_cur.ret_flag = ret_flag_now;
    // writes to the status register are dropped: all its fields are read only
    if (wr && hit_mask(addr))
    begin
      next_cur.base_pri = wdata[exc_status_pkg::BPRI_LSB +: 8];
      next_cur.fmask = wdata[exc_status_pkg::FMASK_BIT];
    end
    // unmapped reads and idle cycles return zero
    next_cur.rdata = 32'h0000_0000;
    if (rd)
    begin
      unique case (addr)
        exc_status_pkg::ICS_OFFSET: next_cur.rdata = ics_word;
        exc_status_pkg::MASK_OFFSET: next_cur.rdata = mask_word;
        default: next_cur.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur.rdata <= exc_status_pkg::RDATA_RESET;
      cur.base_pri <= exc_status_pkg::BPRI_RESET;
      cur.fmask <= exc_status_pkg::FMASK_RESET;
      cur.pend <= exc_status_pkg::VEC_RESET;
      cur.act <= exc_status_pkg::VEC_RESET;
      cur.ret_flag <= exc_status_pkg::RET_FLAG_RESET;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // every output straight from the state register
  assign rdata = cur.rdata;
  assign pending_vector_number = cur.pend;
  assign active_vector_number = cur.act;
  assign return_to_base_flag = cur.ret_flag;
  assign base_priority_mask = cur.base_pri;
  assign fault_mask_a = cur.fmask;

  // checks on the status outputs, all on the one clock
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // helper: ordinary actives present at all
  logic any_ordinary;
  logic fault_only;
  always_comb
  begin
    any_ordinary = 1'b0;
    for (int i = 0; i < exc_status_pkg::NUM_EXC; i++)
    begin
      if (active_in[i] && exc_status_pkg::code_is_ordinary(6'(i)))
      begin
        any_ordinary = 1'b1;
      end
    end
    fault_only = !any_ordinary && active_in[exc_status_pkg::EXC_NMI];
  end

  // level of the exception that the picker chose this cycle, for the base priority check;
  // for nmi and hard fault the level is unused, their place is fixed above every level
  logic [2:0] pick_level;
  assign pick_level = prio_in[winner * exc_status_pkg::PRIO_W +: exc_status_pkg::PRIO_W];

  property p_pend_follows;
    logic [5:0] w;
    (1'b1, w = winner) |=> pending_vector_number == w;
  endproperty
  AST_PEND_FOLLOWS_PICK: assert property (p_pend_follows)
    else $error("pending field does not follow the chosen exception");

  AST_PEND_NEVER_RESERVED: assert property (
    pending_vector_number == exc_status_pkg::EXC_NONE ||
    exc_status_pkg::code_is_legal(pending_vector_number))
    else $error("pending field shows a reserved code");

  AST_FMASK_ONLY_NMI: assert property (
    fault_mask_a && !$past(wr) ##1 pending_vector_number != exc_status_pkg::EXC_NONE
    |-> pending_vector_number == exc_status_pkg::EXC_NMI)
    else $error("fault mask let a maskable exception into the pending field");

  AST_ACT_EQUALS_STATUS: assert property (
    exc_status_pkg::code_is_legal(handler_exception_number)
    |=> active_vector_number == $past(handler_exception_number))
    else $error("active field differs from the handler number");

  AST_ACT_ZERO_THREAD: assert property (
    handler_exception_number == exc_status_pkg::EXC_NONE [*2]
    |-> active_vector_number == exc_status_pkg::EXC_NONE)
    else $error("active field not zero in thread mode");

  AST_RET_FLAG_NONE_ACTIVE: assert property (
    !any_ordinary |=> return_to_base_flag)
    else $error("return flag low with no ordinary active exception");

  AST_RET_FLAG_PREEMPTED: assert property (
    (|others) |=> !return_to_base_flag)
    else $error("return flag high with a preempted exception left");

  AST_RET_FLAG_IGNORES_NMI: assert property (
    fault_only |=> return_to_base_flag)
    else $error("return flag counted the nmi");

  AST_RSVD_BITS_ZERO: assert property (
    rd && addr == exc_status_pkg::ICS_OFFSET
    |=> rdata[exc_status_pkg::RSVD_MSB:exc_status_pkg::RSVD_LSB] == 5'h00)
    else $error("reserved status bits read nonzero");

  AST_WRITE_IGNORED: assert property (
    wr && addr == exc_status_pkg::ICS_OFFSET ##1 rd && addr == exc_status_pkg::ICS_OFFSET
    |=> rdata[exc_status_pkg::ACT_LSB +: 6] == $past(active_vector_number))
    else $error("write changed the read-only status image");

  AST_RDATA_ONE_CYCLE: assert property (
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data stands outside its cycle");

  // pick order: nmi first, hard fault next, nothing shown without a request
  AST_PEND_NMI_FIRST: assert property (
    pend_in[exc_status_pkg::EXC_NMI] && enable_in[exc_status_pkg::EXC_NMI]
    |=> pending_vector_number == exc_status_pkg::EXC_NMI)
    else $error("pending nmi did not win");

  AST_PEND_HARD_NEXT: assert property (
    pend_in[exc_status_pkg::EXC_HARD] && enable_in[exc_status_pkg::EXC_HARD] && !fault_mask_a &&
    !(pend_in[exc_status_pkg::EXC_NMI] && enable_in[exc_status_pkg::EXC_NMI])
    |=> pending_vector_number == exc_status_pkg::EXC_HARD)
    else $error("pending hard fault lost to a programmable level");

  AST_PEND_ZERO_NO_REQ: assert property (
    (pend_in & enable_in) == 64'h0000_0000_0000_0000
    |=> pending_vector_number == exc_status_pkg::EXC_NONE)
    else $error("pending field set with nothing pending and enabled");

  // a base level hides every programmable level at or below it in urgency
  AST_BASE_LEVEL_HIDES: assert property (
    base_priority_mask[7:exc_status_pkg::BPRI_IMPL_LSB] != 3'h0 && winner > exc_status_pkg::EXC_HARD
    |-> pick_level < base_priority_mask[7:exc_status_pkg::BPRI_IMPL_LSB])
    else $error("base priority let a masked level into the pick");

  // the fault mask hides everything but nmi, hard fault included
  AST_FMASK_HIDES_ALL: assert property (
    fault_mask_a && !(pend_in[exc_status_pkg::EXC_NMI] && enable_in[exc_status_pkg::EXC_NMI])
    |=> pending_vector_number == exc_status_pkg::EXC_NONE)
    else $error("fault mask left a maskable exception visible");

  AST_ACT_NEVER_RESERVED: assert property (
    active_vector_number == exc_status_pkg::EXC_NONE ||
    exc_status_pkg::code_is_legal(active_vector_number))
    else $error("active field shows a reserved code");

  AST_ACT_HANDLER_RSVD: assert property (
    !exc_status_pkg::code_is_legal(handler_exception_number)
    |=> active_vector_number == exc_status_pkg::EXC_NONE)
    else $error("active field passed a reserved handler code");

  // inside a handler that is the only active exception the flag must be high
  AST_RET_HANDLER_ALONE: assert property (
    handler_exception_number != exc_status_pkg::EXC_NONE &&
    active_in == (64'h0000_0000_0000_0001 << handler_exception_number)
    |=> return_to_base_flag)
    else $error("return flag low inside the only active handler");

  // register port images and the read-only status word
  AST_STATUS_UPPER_ZERO: assert property (
    rd && hit_status(addr) |=> (rdata >> (exc_status_pkg::PEND_LSB + 6)) == 32'h0000_0000)
    else $error("status bits above the pending field read nonzero");

  AST_STATUS_READ_IMAGE: assert property (
    rd && hit_status(addr)
    |=> rdata[exc_status_pkg::PEND_LSB +: 6] == $past(pending_vector_number) &&
    rdata[exc_status_pkg::RET_FLAG_BIT] == $past(return_to_base_flag) &&
    rdata[exc_status_pkg::ACT_LSB +: 6] == $past(active_vector_number))
    else $error("status read does not show the live fields");

  AST_STATUS_WRITE_NO_MASK: assert property (
    wr && hit_status(addr) |=> $stable(base_priority_mask) && $stable(fault_mask_a))
    else $error("write to the status word changed the mask register");

  AST_MASK_WRITE_LANDS: assert property (
    wr && hit_mask(addr)
    |=> base_priority_mask == $past(wdata[exc_status_pkg::BPRI_LSB +: 8]) &&
    fault_mask_a == $past(wdata[exc_status_pkg::FMASK_BIT]))
    else $error("mask write did not land");

  AST_MASK_READ_IMAGE: assert property (
    rd && hit_mask(addr)
    |=> rdata[exc_status_pkg::BPRI_LSB +: 8] == $past(base_priority_mask) &&
    rdata[exc_status_pkg::FMASK_BIT] == $past(fault_mask_a))
    else $error("mask read does not show the register");

  AST_UNMAPPED_READ_ZERO: assert property (
    rd && !hit_status(addr) && !hit_mask(addr) |=> rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  COV_PEND_IRQ: cover property (pending_vector_number >= exc_status_pkg::EXC_IRQ0);
  COV_NESTED: cover property (return_to_base_flag ##1 !return_to_base_flag);
  COV_FMASK_NMI: cover property (fault_mask_a ##1 pending_vector_number == exc_status_pkg::EXC_NMI);
  COV_BASE_LEVEL_MASKS: cover property (base_priority_mask != 8'h00 && pend_in != 64'h0
    ##1 pending_vector_number == exc_status_pkg::EXC_NONE);
  COV_ICS_READ: cover property (rd && addr == exc_status_pkg::ICS_OFFSET);
endmodule : exception_vector_status

//--- hw/exc_prio_pick.sv
// shared constants of the exception status block and the pending-exception picker
// Notes on behaviour
// - pending field shows the highest priority exception that is pending and enabled.
// - pending field obeys base priority and fault mask, never the primary mask.
// - codes: none 00, nmi 02, faults 03-06, svc 0B, pendsv 0E, tick 0F, irq 10 up.
// - reserved codes 01, 07-0A, 0C, 0D, 3C-3F are never reported.
// - return flag 0 with preempted actives left, 1 when none or only current active.
// - return flag looks only at ordinary interrupts, not at nmi or faults.
// - return flag means something only while a handler runs.
// - active field holds the exception being serviced, same numbering.
// - active field is zero in thread mode and when the handler number is a reserved code.
// - active field equals the handler number of the program status unless that number is reserved.
// - bits 10:6 read zero; software keeps them on read-modify-write.
`timescale 1ns/10ps
package exc_status_pkg;
  // register map, byte offsets on the plain register port
  localparam int ADDR_W = 8;
  localparam logic [7:0] ICS_OFFSET = 8'h00;
  localparam logic [7:0] MASK_OFFSET = 8'h04;
  // status register layout
  localparam int PEND_LSB = 12;
  localparam int RET_FLAG_BIT = 11;
  localparam int RSVD_LSB = 6;
  localparam int RSVD_MSB = 10;
  localparam int ACT_LSB = 0;
  // mask register layout: base priority byte, fault mask bit
  localparam int BPRI_LSB = 0;
  localparam int BPRI_IMPL_LSB = 5;
  localparam int FMASK_BIT = 8;
  // reset values
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [7:0] BPRI_RESET = 8'h00;
  localparam logic FMASK_RESET = 1'b0;
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic RET_FLAG_RESET = 1'b0;
  // exception numbering
  localparam int NUM_EXC = 64;
  localparam int PRIO_W = 3;
  localparam int EFF_W = 4;
  localparam logic [5:0] EXC_NONE = 6'h00;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD = 6'h03;
  localparam logic [5:0] EXC_USAGE = 6'h06;
  localparam logic [5:0] EXC_SVC = 6'h0B;
  localparam logic [5:0] EXC_DEBUG = 6'h0C;
  localparam logic [5:0] EXC_RSVD_D = 6'h0D;
  localparam logic [5:0] EXC_IRQ0 = 6'h10;
  localparam logic [5:0] EXC_LAST = 6'h3B;
  // effective priority: nmi and hard fault sit above every programmable level
  localparam logic [EFF_W-1:0] EFF_NMI = 4'h0;
  localparam logic [EFF_W-1:0] EFF_HARD = 4'h1;
  localparam logic [EFF_W-1:0] EFF_PROG_BASE = 4'h2;
  localparam logic [EFF_W-1:0] EFF_NONE = 4'hF;

  // true for a code that names a real exception
  function automatic logic code_is_legal(input logic [5:0] code);
    code_is_legal = (code >= EXC_NMI && code <= EXC_USAGE) || code == EXC_SVC ||
      (code > EXC_RSVD_D && code <= EXC_LAST);
  endfunction : code_is_legal

  // ordinary interrupts: everything legal from supervisor call upward
  function automatic logic code_is_ordinary(input logic [5:0] code);
    code_is_ordinary = code_is_legal(code) && code >= EXC_SVC;
  endfunction : code_is_ordinary
endpackage : exc_status_pkg

module exc_prio_pick (
  input wire logic [63:0] pend_in, // pending flag per exception number
  input wire logic [63:0] enable_in, // enable flag per exception number
  input wire logic [191:0] prio_in, // 3-bit priority per exception number
  input wire logic [2:0] base_pri, // implemented base priority bits, 0 = off
  input wire logic fmask, // fault mask: only nmi stays eligible
  output logic [5:0] winner // chosen exception number, 0 when none
);
  localparam int EFF_W_L = exc_status_pkg::EFF_W;
  logic [63:0] elig;
  logic [EFF_W_L-1:0] eff [64];

  // per exception eligibility and effective priority
  for (genvar i = 0; i < exc_status_pkg::NUM_EXC; i++)
  begin : g_exc
    localparam logic [5:0] CODE = 6'(i);
    logic [2:0] p;
    assign p = prio_in[i*exc_status_pkg::PRIO_W +: exc_status_pkg::PRIO_W];
    assign eff[i] = (CODE == exc_status_pkg::EXC_NMI) ? exc_status_pkg::EFF_NMI :
      (CODE == exc_status_pkg::EXC_HARD) ? exc_status_pkg::EFF_HARD :
      exc_status_pkg::EFF_PROG_BASE + {1'b0, p};
    // primary mask deliberately absent: the field shows what would preempt without it
    assign elig[i] = pend_in[i] && enable_in[i] && exc_status_pkg::code_is_legal(CODE) &&
      !(fmask && CODE != exc_status_pkg::EXC_NMI) &&
      !(base_pri != 3'h0 && CODE > exc_status_pkg::EXC_HARD && p >= base_pri);
  end

  // lowest effective priority wins, lowest number breaks a tie
  always_comb
  begin
    logic [EFF_W_L-1:0] best;
    best = exc_status_pkg::EFF_NONE;
    winner = exc_status_pkg::EXC_NONE;
    for (int i = 0; i < exc_status_pkg::NUM_EXC; i++)
    begin
      if (elig[i] && eff[i] < best)
      begin
        best = eff[i];
        winner = 6'(i);
      end
    end
  end
endmodule : exc_prio_pick

//--- testbench/tb.sv
// self-checking bench of the exception vector status block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [63:0] pend_in = 64'h0000_0000_0000_0010;
  logic [63:0] enable_in = 64'hFFFF_FFFF_FFFF_FFFF;
  logic [191:0] prio_in = 192'h0;
  logic [63:0] active_in = 64'h0;
  logic [5:0] handler_exception_number = 6'h00;
  logic [5:0] pending_vector_number;
  logic [5:0] active_vector_number;
  logic return_to_base_flag;
  logic [7:0] base_priority_mask;
  logic fault_mask_a;
  int err_total = 0;
  int n_compared = 0;
  logic [31:0] rv;
  logic [5:0] legal_c [10] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0B, 6'h0E, 6'h0F, 6'h10, 6'h3B};
  logic [5:0] rsvd_c [11] = '{6'h01, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0C, 6'h0D, 6'h3C, 6'h3D, 6'h3E, 6'h3F};

  // 10 MHz system clock
  always #50 clk = ~clk;

  exception_vector_status u_dut (
    .clk(clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .pend_in(pend_in),
    .enable_in(enable_in),
    .prio_in(prio_in),
    .active_in(active_in),
    .handler_exception_number(handler_exception_number),
    .pending_vector_number(pending_vector_number),
    .active_vector_number(active_vector_number),
    .return_to_base_flag(return_to_base_flag),
    .base_priority_mask(base_priority_mask),
    .fault_mask_a(fault_mask_a)
  );

  // one-cycle write strobe
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr

  // one-cycle read strobe; data is only valid in the following cycle
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  // outputs are registered, so look one edge after the inputs land
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle

  task automatic pend_chk(input logic [63:0] p, input logic [5:0] exp);
    @(posedge clk);
    pend_in <= p;
    settle;
    `CHK("pending", exp, pending_vector_number)
  endtask : pend_chk

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // guard against a hang of the main sequence
  initial
  begin
    #1000000;
    err_total++;
    print_verdict;
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    #1 `CHK("rst pend", exc_status_pkg::VEC_RESET, pending_vector_number)
    `CHK("rst flag", exc_status_pkg::RET_FLAG_RESET, return_to_base_flag)
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle;
    `CHK("pend load", 6'h04, pending_vector_number)
    // each fixed legal code and the first and last irq alone, then every reserved code as pending and as handler
    foreach (legal_c[i]) pend_chk(64'h1 << legal_c[i], legal_c[i]);
    foreach (rsvd_c[i])
    begin
      @(posedge clk);
      handler_exception_number <= rsvd_c[i];
      pend_chk(64'h1 << rsvd_c[i], 6'h00);
      `CHK("act rsvd", 6'h00, active_vector_number)
    end
    // ordering: nmi, hard fault, programmed level, lower code on tie, enable
    @(posedge clk);
    prio_in[3*16 +: 3] <= 3'h1;
    prio_in[3*4 +: 3] <= 3'h2;
    prio_in[3*17 +: 3] <= 3'h4;
    prio_in[3*18 +: 3] <= 3'h5;
    pend_chk(64'h0C, 6'h02);
    pend_chk(64'h1_0018, 6'h03);
    pend_chk(64'h1_0010, 6'h10);
    pend_chk(64'h6_0000, 6'h11);
    pend_chk(64'h30_0000, 6'h14);
    @(posedge clk);
    enable_in[6'h14] <= 1'b0;
    pend_chk(64'h30_0000, 6'h15);
    // base priority level 4 hides levels 4 and up, level 5 lets level 4 through
    bus_wr(exc_status_pkg::MASK_OFFSET, 32'h0000_0080);
    pend_chk(64'h6_0000, 6'h00);
    bus_wr(exc_status_pkg::MASK_OFFSET, 32'h0000_00A0);
    pend_chk(64'h6_0000, 6'h11);
    `CHK("base", 8'hA0, base_priority_mask)
    bus_wr(exc_status_pkg::MASK_OFFSET, 32'h0000_0020);
    pend_chk(64'h1_0008, 6'h03);
    // fault mask leaves only nmi
    bus_wr(exc_status_pkg::MASK_OFFSET, 32'h0000_0100);
    pend_chk(64'h1_0008, 6'h00);
    pend_chk(64'h1_000C, 6'h02);
    bus_rd(exc_status_pkg::MASK_OFFSET, rv);
    `CHK("mask reg", 32'h0000_0100, rv)
    `CHK("fmask", 1'b1, fault_mask_a)
    bus_wr(exc_status_pkg::MASK_OFFSET, 32'h0000_0000);
    // active field and return flag
    @(posedge clk);
    handler_exception_number <= 6'h12;
    active_in <= 64'h4_0000;
    pend_in <= 64'h8000;
    settle;
    `CHK("act", 6'h12, active_vector_number)
    `CHK("irq index", 6'h02, active_vector_number - 6'h10)
    `CHK("ret only", 1'b1, return_to_base_flag)
    @(posedge clk);
    active_in <= 64'h6_0000;
    settle;
    `CHK("ret nested", 1'b0, return_to_base_flag)
    bus_rd(exc_status_pkg::ICS_OFFSET, rv);
    `CHK("status", {14'h0, 6'h0F, 1'b0, 5'h00, 6'h12}, rv)
    #100 `CHK("rdata drop", 32'h0, rdata)
    @(posedge clk);
    active_in <= 64'h4_0008;
    settle;
    `CHK("ret fault", 1'b1, return_to_base_flag)
    // writes to the status word change nothing
    bus_wr(exc_status_pkg::ICS_OFFSET, 32'hFFFF_FFFF);
    bus_rd(exc_status_pkg::ICS_OFFSET, rv);
    `CHK("status ro", {14'h0, 6'h0F, 1'b1, 5'h00, 6'h12}, rv)
    bus_rd(8'h08, rv);
    `CHK("unmapped", 32'h0, rv)
    // thread mode
    @(posedge clk);
    handler_exception_number <= 6'h00;
    active_in <= 64'h0;
    pend_in <= 64'h0;
    settle;
    `CHK("thread", 6'h00, active_vector_number)
    `CHK("pend none", 6'h00, pending_vector_number)
    `CHK("ret none", 1'b1, return_to_base_flag)
    print_verdict;
  end
endmodule : tb
